// >>> design/cig_consts.svh
`ifndef CIG_CONSTS_SVH
`define CIG_CONSTS_SVH
// ****************************************
// register map
// ****************************************
`define CIG_ADDR_W 4
`define CIG_OFS_OPTIONS 4'h0
`define CIG_OFS_CONTROL 4'h1
`define CIG_OFS_STATUS 4'h2
`define CIG_OFS_UIO_OUT 4'h3
`define CIG_OFS_UIO_OE 4'h4
`define CIG_OFS_UIO_IN 4'h5
// option bits
`define CIG_OPT_USRCLK 0
`define CIG_OPT_USRCLK_SCLK 1
`define CIG_OPT_INIT_FLAG 2
`define CIG_OPT_TERM_GATE 3
`define CIG_OPT_GOE 4
`define CIG_OPT_GCLR 5
`define CIG_OPT_RST 8'h00
// control bits
`define CIG_CTL_FRAME1 0
`define CIG_CTL_INIT_DONE 1
// ****************************************
// timing
// ****************************************
`define CIG_SCLK_DIV 4'h2
`endif

// >>> design/cig_pkg.sv
`default_nettype none
package cig_pkg;
  typedef enum logic [1:0] {
    CIG_RESET,
    CIG_LOADING,
    CIG_INITIALISING,
    CIG_USER
  } cig_state_t;
endpackage : cig_pkg
`default_nettype wire

// >>> design/cig_pin_cell.sv
`default_nettype none
module cig_pin_cell (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic user_o_i,
  input wire logic user_oe_i,
  input wire logic tri_all_i,
  output logic pin_o,
  output logic pin_oe_o
);
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pin_o <= 1'b0;
      pin_oe_o <= 1'b0;
    end else begin
      pin_o <= user_o_i;
      pin_oe_o <= user_oe_i & ~tri_all_i;
    end
  end
endmodule // cig_pin_cell
`default_nettype wire

// >>> design/cig_top.sv
// Summary of operation
// - with the start-up clock option on, the user start-up clock times initialisation, else it is user I/O.
// - in the active serial scheme a clock-source option makes the user start-up clock the serial clock source.
// - while the configuration request is low the init-complete flag is released.
// - once the first frame loads the flag-enable bit, the init-complete flag is driven low.
// - at the end of initialisation the flag is released and user mode is entered.
// - with termination gating on, release waits for termination calibration done, else that input is ignored.
// - with the global output enable option on, a low on it tri-states every I/O pin.
// - with the global clear option on, a low on it clears every user register.
// - with its option off the start-up clock pin is user I/O, tri-stated in configuration, when flag (option off), GOE and clear pins get weak pull-up.
`include "cig_consts.svh"
`default_nettype none
module cig_top #(
  parameter int NUM_IO = 8
) (
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic CONFIG_REQUEST_N_I,
  input wire logic [`CIG_ADDR_W-1:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [7:0] RDATA_O,
  input wire logic USER_STARTUP_CLOCK_I,
  output logic USER_STARTUP_CLOCK_O,
  output logic USER_STARTUP_CLOCK_OE_O,
  output logic CONFIG_SERIAL_CLOCK_O,
  input wire logic INIT_COMPLETE_FLAG_I,
  output logic INIT_COMPLETE_FLAG_O,
  output logic INIT_COMPLETE_FLAG_OE_O,
  output logic INIT_COMPLETE_FLAG_PULLUP_O,
  input wire logic TERMINATION_CALIBRATION_DONE_I,
  input wire logic GLOBAL_OUTPUT_ENABLE_I,
  output logic GLOBAL_OUTPUT_ENABLE_PULLUP_O,
  input wire logic GLOBAL_REGISTER_CLEAR_N_I,
  output logic GLOBAL_REGISTER_CLEAR_N_PULLUP_O,
  input wire logic [NUM_IO-1:0] USER_IO_I,
  output logic [NUM_IO-1:0] USER_IO_O,
  output logic [NUM_IO-1:0] USER_IO_OE_O,
  output logic USER_MODE_O
);
  import cig_pkg::*;

  // ****************************************
  // option and control registers
  // ****************************************
  cig_state_t state_q, state_d;
  logic [7:0] options_q;
  logic frame1_q, init_done_q;
  logic [NUM_IO-1:0] uio_out_q, uio_oe_q;
  logic usrclk_meta_q, usrclk_sync_q, usrclk_prev_q;
  logic [3:0] div_cnt_q;
  logic sclk_q;
  logic flag_low_q, flag_pullup_q;
  logic usr_mode_q;

  wire opt_usrclk = options_q[`CIG_OPT_USRCLK];
  wire opt_sclk_src = options_q[`CIG_OPT_USRCLK_SCLK];
  wire opt_flag = options_q[`CIG_OPT_INIT_FLAG];
  wire opt_term = options_q[`CIG_OPT_TERM_GATE];
  wire opt_goe = options_q[`CIG_OPT_GOE];
  wire opt_gclr = options_q[`CIG_OPT_GCLR];
  wire configuring = (state_q != CIG_USER);

  wire wr_opt = WR_I && (ADDR_I == `CIG_OFS_OPTIONS);
  wire wr_ctl = WR_I && (ADDR_I == `CIG_OFS_CONTROL);
  wire wr_out = WR_I && (ADDR_I == `CIG_OFS_UIO_OUT);
  wire wr_oe = WR_I && (ADDR_I == `CIG_OFS_UIO_OE);
  // global clear only hits user-mode registers, not the configuration itself
  wire gclr = opt_gclr && !GLOBAL_REGISTER_CLEAR_N_I;
  wire goe_off = opt_goe && !GLOBAL_OUTPUT_ENABLE_I;

  // start-up clock edge; usrclk_meta_q only feeds usrclk_sync_q
  wire usrclk_edge = usrclk_sync_q && !usrclk_prev_q;
  wire init_tick = opt_usrclk ? usrclk_edge : 1'b1;
  wire term_ok = !opt_term || TERMINATION_CALIBRATION_DONE_I;

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      usrclk_meta_q <= 1'b0;
      usrclk_sync_q <= 1'b0;
      usrclk_prev_q <= 1'b0;
    end else begin
      usrclk_meta_q <= USER_STARTUP_CLOCK_I;
      usrclk_sync_q <= usrclk_meta_q;
      usrclk_prev_q <= usrclk_sync_q;
    end
  end

  // ****************************************
  // configuration sequence
  // ****************************************
  always_comb begin
    state_d = state_q;
    case (state_q)
      CIG_RESET: if (CONFIG_REQUEST_N_I) state_d = CIG_LOADING;
      CIG_LOADING: if (frame1_q) state_d = CIG_INITIALISING;
      CIG_INITIALISING: if (init_done_q && term_ok && init_tick) state_d = CIG_USER;
      CIG_USER: state_d = CIG_USER;
      default: state_d = CIG_RESET;
    endcase
    if (!CONFIG_REQUEST_N_I) state_d = CIG_RESET;
  end

  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_q <= CIG_RESET;
      options_q <= `CIG_OPT_RST;
      frame1_q <= 1'b0;
      init_done_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (!CONFIG_REQUEST_N_I) begin
        frame1_q <= 1'b0;
        init_done_q <= 1'b0;
      end else begin
        // first frame carries the option bits
        if (wr_opt && state_q == CIG_LOADING) options_q <= WDATA_I;
        if (wr_ctl && WDATA_I[`CIG_CTL_FRAME1]) frame1_q <= 1'b1;
        if (wr_ctl && WDATA_I[`CIG_CTL_INIT_DONE]) init_done_q <= 1'b1;
      end
    end
  end

  // ****************************************
  // init-complete flag, open drain
  // ****************************************
  wire flag_low_d = opt_flag && (state_d == CIG_INITIALISING);
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      flag_low_q <= 1'b0;
      flag_pullup_q <= 1'b1;
      usr_mode_q <= 1'b0;
    end else begin
      flag_low_q <= flag_low_d;
      flag_pullup_q <= configuring && !opt_flag;
      usr_mode_q <= (state_d == CIG_USER);
    end
  end
  assign INIT_COMPLETE_FLAG_O = 1'b0;
  assign INIT_COMPLETE_FLAG_OE_O = flag_low_q;
  assign INIT_COMPLETE_FLAG_PULLUP_O = flag_pullup_q;
  assign USER_MODE_O = usr_mode_q;

  // ****************************************
  // serial clock from start-up clock or divider
  // ****************************************
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      div_cnt_q <= 4'h0;
      sclk_q <= 1'b0;
    end else if (opt_sclk_src) begin
      sclk_q <= usrclk_sync_q;
      div_cnt_q <= 4'h0;
    end else if (div_cnt_q == `CIG_SCLK_DIV - 4'h1) begin
      div_cnt_q <= 4'h0;
      sclk_q <= !sclk_q;
    end else begin
      div_cnt_q <= div_cnt_q + 4'h1;
    end
  end
  assign CONFIG_SERIAL_CLOCK_O = sclk_q;

  // ****************************************
  // optional pins as user I/O
  // ****************************************
  logic usr_pin_o_q, usr_pin_oe_q, goe_pu_q, gclr_pu_q;
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      uio_out_q <= '0;
      uio_oe_q <= '0;
      usr_pin_o_q <= 1'b0;
      usr_pin_oe_q <= 1'b0;
      goe_pu_q <= 1'b1;
      gclr_pu_q <= 1'b1;
    end else begin
      if (gclr) begin
        uio_out_q <= '0;
        uio_oe_q <= '0;
      end else begin
        if (wr_out) uio_out_q <= WDATA_I[NUM_IO-1:0];
        if (wr_oe) uio_oe_q <= WDATA_I[NUM_IO-1:0];
      end
      // start-up clock pin becomes user I/O bit 0 mirror when option off
      usr_pin_o_q <= uio_out_q[0];
      usr_pin_oe_q <= !opt_usrclk && !configuring && uio_oe_q[0] && !goe_off;
      goe_pu_q <= configuring;
      gclr_pu_q <= configuring;
    end
  end
  assign USER_STARTUP_CLOCK_O = usr_pin_o_q;
  assign USER_STARTUP_CLOCK_OE_O = usr_pin_oe_q;
  assign GLOBAL_OUTPUT_ENABLE_PULLUP_O = goe_pu_q;
  assign GLOBAL_REGISTER_CLEAR_N_PULLUP_O = gclr_pu_q;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_IO; gi++) begin : g_io
      cig_pin_cell u_cell (
        .clk_i(MCLK_I),
        .rst_n_i(RESETN_I),
        .user_o_i(uio_out_q[gi]),
        .user_oe_i(uio_oe_q[gi] && !configuring),
        .tri_all_i(goe_off),
        .pin_o(USER_IO_O[gi]),
        .pin_oe_o(USER_IO_OE_O[gi])
      );
    end
  endgenerate

  // ****************************************
  // read port
  // ****************************************
  logic [7:0] rd_mux;
  always_comb begin
    rd_mux = 8'h00;
    if (ADDR_I == `CIG_OFS_OPTIONS) rd_mux = options_q;
    else if (ADDR_I == `CIG_OFS_CONTROL) rd_mux = {6'h00, init_done_q, frame1_q};
    else if (ADDR_I == `CIG_OFS_STATUS)
      rd_mux = {3'h0, INIT_COMPLETE_FLAG_I, TERMINATION_CALIBRATION_DONE_I,
                usr_mode_q, state_q};
    else if (ADDR_I == `CIG_OFS_UIO_OUT) rd_mux = 8'(uio_out_q);
    else if (ADDR_I == `CIG_OFS_UIO_OE) rd_mux = 8'(uio_oe_q);
    else if (ADDR_I == `CIG_OFS_UIO_IN) rd_mux = 8'(USER_IO_I);
  end
  always_ff @(posedge MCLK_I or negedge RESETN_I) begin
    if (!RESETN_I) RDATA_O <= 8'h00;
    else if (RD_I) RDATA_O <= rd_mux;
    else RDATA_O <= 8'h00;
  end
endmodule // cig_top
`default_nettype wire

// >>> test/cig_top_sva.sv
`default_nettype none
module cig_top_sva #(
  parameter int NUM_IO = 8
) (
  input wire logic MCLK_I,
  input wire logic RESETN_I,
  input wire logic CONFIG_REQUEST_N_I,
  input wire logic [3:0] ADDR_I,
  input wire logic RD_I,
  input wire logic [7:0] RDATA_O,
  input wire logic INIT_COMPLETE_FLAG_O,
  input wire logic INIT_COMPLETE_FLAG_OE_O,
  input wire logic [NUM_IO-1:0] USER_IO_OE_O,
  input wire logic USER_STARTUP_CLOCK_OE_O,
  input wire logic USER_MODE_O
);
  // ****************************************
  // port checks
  // ****************************************
  default clocking cb @(posedge MCLK_I); endclocking
  default disable iff (!RESETN_I);
  flag_open_drain_a: assert property (!INIT_COMPLETE_FLAG_O)
    else $error("flag data not low");
  req_release_a: assert property (
    !CONFIG_REQUEST_N_I |=> !INIT_COMPLETE_FLAG_OE_O && !USER_MODE_O)
    else $error("flag or mode held during request");
  user_flag_a: assert property (USER_MODE_O |-> !INIT_COMPLETE_FLAG_OE_O)
    else $error("flag pulled in user mode");
  flag_release_a: assert property (
    $fell(INIT_COMPLETE_FLAG_OE_O) && $past(CONFIG_REQUEST_N_I) |-> USER_MODE_O)
    else $error("flag released without user mode");
  config_io_a: assert property (
    !USER_MODE_O && !$past(USER_MODE_O) |-> USER_IO_OE_O == '0 && !USER_STARTUP_CLOCK_OE_O)
    else $error("user pin driven during config");
  read_idle_a: assert property (!$past(RD_I) |-> RDATA_O == 8'h00)
    else $error("read data without read");
  unmapped_read_a: assert property ($past(RD_I) && $past(ADDR_I) > 4'h5 |-> RDATA_O == 8'h00)
    else $error("unmapped read not zero");
  status_mode_a: assert property (
    $past(RD_I) && $past(ADDR_I) == 4'h2 |-> RDATA_O[2] == $past(USER_MODE_O)
    && (RDATA_O[1:0] == 2'h3) == $past(USER_MODE_O))
    else $error("status mode wrong");
  cover property ($rose(USER_MODE_O));
  cover property ($rose(INIT_COMPLETE_FLAG_OE_O));
  cover property ($past(RD_I) && $past(ADDR_I) == 4'h2);
endmodule // cig_top_sva
bind cig_top cig_top_sva #(.NUM_IO(NUM_IO)) u_sva (.MCLK_I(MCLK_I), .RESETN_I(RESETN_I),
  .CONFIG_REQUEST_N_I(CONFIG_REQUEST_N_I), .ADDR_I(ADDR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
  .INIT_COMPLETE_FLAG_O(INIT_COMPLETE_FLAG_O), .INIT_COMPLETE_FLAG_OE_O(INIT_COMPLETE_FLAG_OE_O),
  .USER_IO_OE_O(USER_IO_OE_O), .USER_STARTUP_CLOCK_OE_O(USER_STARTUP_CLOCK_OE_O),
  .USER_MODE_O(USER_MODE_O));
`default_nettype wire

// >>> test/cig_board.sv
`default_nettype none
module cig_board (
  input wire logic clk_i,
  input wire logic flag_oe_i,
  input wire logic flag_o_i,
  output logic flag_w_o,
  output logic start_clk_o,
  output int rises_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // board side
  // ****************************************
  logic prev_q = 1'b1;
  int rise_q = 0;
  // external pull-up: a released flag reads high
  assign flag_w_o = flag_oe_i ? flag_o_i : 1'b1;
  assign rises_o = rise_q;
  // free-running start-up clock; its edges land on core falling edges, clear of sampling
  initial begin
    start_clk_o = 1'b0;
    forever #200 start_clk_o = ~start_clk_o;
  end
  always @(posedge clk_i) begin
    prev_q <= flag_w_o;
    if (flag_w_o && !prev_q) rise_q <= rise_q + 1;
  end
endmodule // cig_board
`default_nettype wire

// >>> test/config_init_global_controls_tb_top.sv
`default_nettype none
module config_init_global_controls_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // ****************************************
  // bench
  // ****************************************
  logic clk = 0, rstn = 0, req_n = 1, wr = 0, rd = 0, term = 0, goe = 1, gclr_n = 1;
  logic [3:0] addr = '0;
  logic [7:0] wdata = '0, uio_in = '0, rdata, uio_o, uio_oe, val, rnd;
  logic flag_o, flag_oe, flag_w, sclk, umode, pu_goe;
  logic uclk_o, uclk_oe, sclk_o, flag_pu, pu_gclr;
  int fails = 0, checks = 0, cyc = 0, rises, m_opt;
  always #20 clk = ~clk;
  cig_top uut (.MCLK_I(clk), .RESETN_I(rstn), .CONFIG_REQUEST_N_I(req_n), .ADDR_I(addr),
    .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .USER_STARTUP_CLOCK_I(sclk),
    .USER_STARTUP_CLOCK_O(uclk_o), .USER_STARTUP_CLOCK_OE_O(uclk_oe),
    .CONFIG_SERIAL_CLOCK_O(sclk_o),
    .INIT_COMPLETE_FLAG_I(flag_w), .INIT_COMPLETE_FLAG_O(flag_o),
    .INIT_COMPLETE_FLAG_OE_O(flag_oe), .INIT_COMPLETE_FLAG_PULLUP_O(flag_pu),
    .TERMINATION_CALIBRATION_DONE_I(term), .GLOBAL_OUTPUT_ENABLE_I(goe),
    .GLOBAL_OUTPUT_ENABLE_PULLUP_O(pu_goe), .GLOBAL_REGISTER_CLEAR_N_I(gclr_n),
    .GLOBAL_REGISTER_CLEAR_N_PULLUP_O(pu_gclr), .USER_IO_I(uio_in), .USER_IO_O(uio_o),
    .USER_IO_OE_O(uio_oe), .USER_MODE_O(umode));
  cig_board u_board (.clk_i(clk), .flag_oe_i(flag_oe), .flag_o_i(flag_o), .flag_w_o(flag_w),
    .start_clk_o(sclk), .rises_o(rises));
  task automatic cmp(string what, logic [7:0] exp, logic [7:0] got);
    checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // idle cycle after each strobe, so no strobe is set twice in one step
  task automatic bus(logic w, logic [3:0] a, logic [7:0] d);
    wr <= w;
    rd <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 0;
    rd <= 0;
    #1 val = rdata;
    @(posedge clk);
  endtask
  // serial clock: synced start-up clock two edges late, or a toggle every second edge
  task automatic sclk_chk(logic src);
    logic hist[$];
    logic outs[$];
    repeat (8) begin
      @(posedge clk);
      hist.push_back(sclk);
      #1 outs.push_back(sclk_o);
    end
    for (int i = 4; i < 8; i++) begin
      if (src) cmp("serial clock", 8'(hist[i-2]), 8'(outs[i]));
      else cmp("serial divider", 8'(!outs[i-2]), 8'(outs[i]));
    end
    @(posedge clk);
  endtask
  task automatic boot(logic [7:0] opt);
    req_n <= 0;
    term <= 0;
    repeat (2) @(posedge clk);
    #1 cmp("flag held", 8'h00, 8'(flag_oe));
    @(posedge clk) req_n <= 1;
    @(posedge clk);
    #1 cmp("pullup", 8'h01, 8'(pu_goe));
    cmp("clear pullup", 8'h01, 8'(pu_gclr));
    cmp("flag pullup", 8'(!m_opt[2]), 8'(flag_pu));
    m_opt = opt;
    @(posedge clk);
    bus(1, 4'h0, opt);
    sclk_chk(opt[1]);
    bus(1, 4'h1, 8'h01);
    #1 cmp("flag low", 8'(opt[2]), 8'(flag_oe));
    @(posedge clk);
    bus(1, 4'h1, 8'h02);
    // wait covers a full start-up clock period
    repeat (40) @(posedge clk);
    #1 cmp("gated mode", 8'(!opt[3]), 8'(umode));
    @(posedge clk) term <= 1;
    repeat (40) @(posedge clk);
    #1 cmp("user mode", 8'h01, 8'(umode));
    cmp("flag released", 8'h00, 8'(flag_oe));
    cmp("user pullup", 8'h00, 8'(flag_pu | pu_goe | pu_gclr));
    @(posedge clk);
    $display("test boot done");
  endtask
  task automatic wrap_up();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc > 2000) begin
      fails++;
      wrap_up();
    end
  end
  initial begin
    void'($urandom(543));
    repeat (2) @(posedge clk);
    rstn <= 1;
    @(posedge clk);
    #1 cmp("reset flag", 8'h00, 8'(flag_oe));
    @(posedge clk);
    boot(8'h3d);
    rnd = 8'($urandom) | 8'h01;
    uio_in <= 8'($urandom);
    bus(1, 4'h3, rnd);
    bus(1, 4'h4, 8'hff);
    repeat (2) @(posedge clk);
    #1 cmp("io out", rnd, uio_o);
    cmp("io oe", 8'hff, uio_oe);
    cmp("clock pin oe", 8'h00, 8'(uclk_oe));
    @(posedge clk) goe <= 0;
    repeat (3) @(posedge clk);
    #1 cmp("io tristate", 8'h00, uio_oe);
    @(posedge clk) goe <= 1;
    gclr_n <= 0;
    repeat (3) @(posedge clk);
    gclr_n <= 1;
    bus(0, 4'h3, 8'h00);
    cmp("cleared out", 8'h00, val);
    bus(1, 4'h0, 8'h00);
    bus(0, 4'h0, 8'h00);
    cmp("options locked", 8'(m_opt), val);
    bus(0, 4'h2, 8'h00);
    cmp("status", {3'h0, 1'b1, term, 1'b1, 2'h3}, val);
    bus(0, 4'hf, 8'h00);
    cmp("unmapped", 8'h00, val);
    cmp("flag rises", 8'h01, 8'(rises));
    $display("test user done");
    boot(8'h06);
    cmp("flag rises", 8'h02, 8'(rises));
    bus(1, 4'h4, 8'h01);
    bus(1, 4'h3, 8'h01);
    #1 cmp("clock pin oe", 8'h01, 8'(uclk_oe));
    cmp("clock pin out", 8'h01, 8'(uclk_o));
    @(posedge clk);
    $display("test pins done");
    wrap_up();
  end
endmodule // config_init_global_controls_tb_top
`default_nettype wire
